// [core/util_decode_pkg.sv]
// Constants for the utility-bus chip-select decoder: register indices,
// reset values, field positions, select codes and decoded I/O addresses.
// Assumes nothing of its surroundings; imported whole by the decoder.
package util_decode_pkg;

  // ****************************************************************
  // Register indices (byte address on APB is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_CS_A = 8'h4e;
  localparam logic [7:0] IDX_CS_B = 8'h4f;
  localparam logic [7:0] IDX_ATTR_C = 8'h54;
  localparam logic [7:0] IDX_ATTR_D = 8'h55;
  localparam logic [7:0] IDX_DEC_CTRL = 8'h58;
  localparam logic [7:0] IDX_STATUS = 8'h59;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_CS_A = 8'h07;
  localparam logic [7:0] RST_CS_B = 8'h4f;
  localparam logic [7:0] RST_ATTR = 8'h00;
  localparam logic [7:0] RST_DEC_CTRL = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int A_EXT_BIOS = 7;
  localparam int A_LOW_BIOS = 6;
  localparam int A_RANGE_SEC = 5;
  localparam int A_IDE_EN = 4;
  localparam int A_FLOP_LOW = 3;
  localparam int A_FLOP_HIGH = 2;
  localparam int A_KBD_EN = 1;
  localparam int A_RTC_EN = 0;
  localparam int B_CFG_EN = 7;
  localparam int B_P92_EN = 6;
  localparam int B_LPT_LSB = 4;
  localparam int B_COMB_LSB = 2;
  localparam int B_COMA_LSB = 0;
  localparam int C_ISA_FWD = 3;
  localparam int C_MEMSEL_EN = 4;

  // ****************************************************************
  // Select codes and sub-codes
  // ****************************************************************
  localparam logic [2:0] CODE_BIOS = 3'h0;
  localparam logic [2:0] CODE_RTC = 3'h1;
  localparam logic [2:0] CODE_KBD = 3'h2;
  localparam logic [2:0] CODE_IDE0 = 3'h3;
  localparam logic [2:0] CODE_FLOPPY = 3'h4;
  localparam logic [2:0] CODE_IDE1 = 3'h5;
  localparam logic [2:0] CODE_GROUP = 3'h6;
  localparam logic [2:0] CODE_IDLE = 3'h7;
  localparam logic [2:0] SUB_COMA = 3'h0;
  localparam logic [2:0] SUB_COMB = 3'h1;
  localparam logic [2:0] SUB_LPT = 3'h2;
  localparam logic [2:0] SUB_CPAGE = 3'h3;
  localparam logic [2:0] SUB_CFGMEM = 3'h4;
  localparam logic [2:0] SUB_NONE = 3'h7;
  localparam logic [1:0] SRC_HOST = 2'h0;

  // ****************************************************************
  // Decoded addresses
  // ****************************************************************
  localparam logic [15:0] IO_IDE_PRI = 16'h01f0;
  localparam logic [15:0] IO_IDE_SEC = 16'h0170;
  localparam logic [15:0] IO_IDECTL_PRI = 16'h03f6;
  localparam logic [15:0] IO_IDECTL_SEC = 16'h0376;
  localparam logic [15:0] IO_FLOP_PRI = 16'h03f0;
  localparam logic [15:0] IO_FLOP_SEC = 16'h0370;
  localparam logic [15:0] IO_KBD = 16'h0060;
  localparam logic [15:0] IO_RTC = 16'h0070;
  localparam logic [15:0] IO_CPAGE = 16'h0c00;
  localparam logic [15:0] IO_CFGMEM = 16'h0800;
  localparam logic [15:0] IO_P92 = 16'h0092;
  localparam logic [15:0] IO_LPT1 = 16'h03bc;
  localparam logic [15:0] IO_LPT2 = 16'h0378;
  localparam logic [15:0] IO_LPT3 = 16'h0278;
  localparam logic [15:0] IO_COM1 = 16'h03f8;
  localparam logic [15:0] IO_COM2 = 16'h02f8;
  localparam logic [15:0] MEM_LOWBIOS = 16'h000e;
  localparam logic [15:0] MEM_LOWBIOS_4G = 16'hfffe;
  localparam logic [15:0] MEM_LOWBIOS_4G1M = 16'hffee;
  localparam logic [15:0] MEM_SEG_C = 16'h000c;
  localparam logic [15:0] MEM_SEG_D = 16'h000d;
  localparam logic [12:0] MEM_EXTBIOS_TOP = 13'h1fff;

endpackage

// [core/util_bus_decode.sv]
// Utility-bus chip-select decoder with an APB register slave.
// Assumes access requests come from logic on core_clk, one request per
// asserted accValid cycle; diskChangeIn is an asynchronous pin.
//
// Summary of operation
// - Extended BIOS enable gates BIOS code and transceiver for FFF80000h-FFFDFFFFh.
// - Lower BIOS enable gives BIOS code; host accesses positive unless memory select on.
// - Lower BIOS enabled keeps ISA/DMA off host bus; else forwarded per bit 3.
// - IDE enable gates IDE codes and transceiver for task-file and control ports.
// - One range bit picks primary or secondary for floppy and IDE; reset primary.
// - Floppy low and high enables; disk-change low forces code 111, no select.
// - Reset sets upper floppy enable, clears lower floppy enable.
// - IDE enabled makes shared control ports give IDE second select, not floppy.
// - Keyboard enable gates its code and transceiver for ports 60h-66h even.
// - Clock enable gates code, latch strobe, chip select, transceiver for 70h-77h.
// - Config enable gates page-port write and window read/write selects.
// - Port 92 access allowed only while its enable is set; reset sets it.
// - Parallel field picks one of three ranges or disabled; reset 00.
// - Serial B field picks range or disables; hit gives port B code; reset 11.
// - Serial A field same encoding, gives port A code; reset 11.
// - Same range on A and B suppresses B, A still decodes.
// - Even attribute bits enable main-memory select for segment reads.
// - Odd attribute bits enable main-memory select for segment writes.
// - Both enables clear or memory select off denies the segment.
// - Bit pairs cover ascending 16 KB segments of C and D areas.
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
module util_bus_decode
  import util_decode_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Access being decoded
  input wire logic accValid,
  input wire logic accIsMem,
  input wire logic accIsWrite,
  input wire logic [1:0] accSource,
  input wire logic [31:0] accAddr,
  input wire logic diskChangeIn,
  // Decoder outputs
  output logic [2:0] encodedSelectCode,
  output logic [2:0] groupSubcode,
  output logic xcvrOutputEnableN,
  output logic floppySelectN,
  output logic diskCtrlSelect1N,
  output logic clockChipLatchN,
  output logic clockChipSelectN,
  output logic configPageSelectN,
  output logic configMemSelectN,
  output logic mainMemSelectN,
  output logic port92Allow,
  output logic isaPositiveDecode,
  output logic hostBusForward
);

  // ****************************************************************
  // Registers and pin synchroniser
  // ****************************************************************
  logic [7:0] csA_q, csB_q, attrC_q, attrD_q, decCtrl_q;
  logic dskMeta_q, dskSync_q;

  // Disk-change pin crosses in on two flops; only dskSync_q is read
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      dskMeta_q <= 1'b0;
      dskSync_q <= 1'b0;
    end else begin
      dskMeta_q <= diskChangeIn;
      dskSync_q <= dskMeta_q;
    end
  end

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire logic [7:0] regIdx = paddr[9:2];
  wire logic idxCsA = regIdx == IDX_CS_A;
  wire logic idxCsB = regIdx == IDX_CS_B;
  wire logic idxAttrC = regIdx == IDX_ATTR_C;
  wire logic idxAttrD = regIdx == IDX_ATTR_D;
  wire logic idxCtrl = regIdx == IDX_DEC_CTRL;
  wire logic idxStat = regIdx == IDX_STATUS;
  wire logic mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                      (idxCsA || idxCsB || idxAttrC || idxAttrD || idxCtrl || idxStat);
  wire logic wrFire = psel && penable && pwrite && mapped;
  wire logic setupPhase = psel && !penable;

  // Zero-wait slave: answer in the first access cycle
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;

  // Software-writable registers; status is read-only
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      csA_q <= RST_CS_A;
      csB_q <= RST_CS_B;
      attrC_q <= RST_ATTR;
      attrD_q <= RST_ATTR;
      decCtrl_q <= RST_DEC_CTRL;
    end else if (wrFire) begin
      if (idxCsA) csA_q <= pwdata[7:0];
      if (idxCsB) csB_q <= pwdata[7:0];
      if (idxAttrC) attrC_q <= pwdata[7:0];
      if (idxAttrD) attrD_q <= pwdata[7:0];
      if (idxCtrl) decCtrl_q <= {3'h0, pwdata[4:3], 3'h0};
    end
  end

  // ****************************************************************
  // Address decode of the current access
  // ****************************************************************
  wire logic [15:0] io = accAddr[15:0];
  wire logic ioAcc = accValid && !accIsMem && (accAddr[31:16] == 16'h0000);
  wire logic memAcc = accValid && accIsMem;
  wire logic fromHost = accSource == SRC_HOST;
  wire logic secRange = csA_q[A_RANGE_SEC];
  wire logic ideEn = csA_q[A_IDE_EN];

  // BIOS areas
  wire logic extBiosAddr = (accAddr[31:19] == MEM_EXTBIOS_TOP) && (accAddr[18:17] != 2'b11);
  wire logic extBiosHit = memAcc && fromHost && csA_q[A_EXT_BIOS] && extBiosAddr;
  wire logic lowBiosAddr = (accAddr[31:16] == MEM_LOWBIOS) ||
                           (accAddr[31:16] == MEM_LOWBIOS_4G) ||
                           (accAddr[31:16] == MEM_LOWBIOS_4G1M);
  wire logic lowBiosHit = memAcc && csA_q[A_LOW_BIOS] && lowBiosAddr;

  // IDE task file and shared control ports
  wire logic [15:0] ideBase = secRange ? IO_IDE_SEC : IO_IDE_PRI;
  wire logic [15:0] ideCtlBase = secRange ? IO_IDECTL_SEC : IO_IDECTL_PRI;
  wire logic ideTaskAddr = ioAcc && (io[15:3] == ideBase[15:3]);
  wire logic ideCtlAddr = ioAcc && (io[15:1] == ideCtlBase[15:1]);
  wire logic ideTaskHit = ideEn && ideTaskAddr;
  wire logic ideCtlHit = ideEn && ideCtlAddr;

  // Floppy: first two ports and the rest of the selected range
  wire logic [15:0] flopBase = secRange ? IO_FLOP_SEC : IO_FLOP_PRI;
  wire logic flopLowAddr = ioAcc && (io[15:1] == flopBase[15:1]);
  wire logic flopHighPri = (io[15:3] == IO_FLOP_PRI[15:3]) && (io[2:1] != 2'b00);
  wire logic flopHighSec = (io[15:4] == IO_FLOP_SEC[15:4]) && (io[3:1] != 3'h0);
  wire logic flopHighAddr = ioAcc && (secRange ? flopHighSec : flopHighPri);
  wire logic flopAddrHit = (csA_q[A_FLOP_LOW] && flopLowAddr) ||
                           (csA_q[A_FLOP_HIGH] && flopHighAddr);
  wire logic flopHit = flopAddrHit && !ideCtlHit;
  wire logic flopBlocked = flopHit && !dskSync_q;

  // Keyboard and clock chip
  wire logic kbdHit = ioAcc && csA_q[A_KBD_EN] && (io[15:3] == IO_KBD[15:3]) && !io[0];
  wire logic rtcHit = ioAcc && csA_q[A_RTC_EN] && (io[15:3] == IO_RTC[15:3]);

  // Configuration RAM: page port on writes only, window on both
  wire logic cfgPageHit = ioAcc && accIsWrite && csB_q[B_CFG_EN] && (io == IO_CPAGE);
  wire logic cfgMemHit = ioAcc && csB_q[B_CFG_EN] && (io[15:8] == IO_CFGMEM[15:8]);
  wire logic p92Hit = ioAcc && csB_q[B_P92_EN] && (io == IO_P92);

  // Parallel port range select
  wire logic [1:0] lptSel = csB_q[B_LPT_LSB +: 2];
  wire logic lptHit = ioAcc && (((lptSel == 2'b00) && (io[15:2] == IO_LPT1[15:2])) ||
                                ((lptSel == 2'b01) && (io[15:3] == IO_LPT2[15:3])) ||
                                ((lptSel == 2'b10) && (io[15:3] == IO_LPT3[15:3])));

  // Serial ports: 10 and 11 both decode nothing
  wire logic [1:0] comASel = csB_q[B_COMA_LSB +: 2];
  wire logic [1:0] comBSel = csB_q[B_COMB_LSB +: 2];
  wire logic com1Addr = io[15:3] == IO_COM1[15:3];
  wire logic com2Addr = io[15:3] == IO_COM2[15:3];
  wire logic comAHit = ioAcc && (((comASel == 2'b00) && com1Addr) ||
                                 ((comASel == 2'b01) && com2Addr));
  wire logic comBRaw = ioAcc && (((comBSel == 2'b00) && com1Addr) ||
                                 ((comBSel == 2'b01) && com2Addr));
  wire logic comBHit = comBRaw && (comBSel != comASel);

  // Expansion ROM segments: C area then D area, 16 KB each, ascending
  wire logic segArea = memAcc && ((accAddr[31:16] == MEM_SEG_C) ||
                                  (accAddr[31:16] == MEM_SEG_D));
  wire logic [7:0] attrSel = accAddr[16] ? attrD_q : attrC_q;
  wire logic [2:0] segBit = {accAddr[15:14], 1'b0};
  wire logic segRead = attrSel[segBit];
  wire logic segWrite = attrSel[segBit + 3'h1];
  wire logic memSelOn = decCtrl_q[C_MEMSEL_EN];
  wire logic mainMemHit = segArea && memSelOn && (accIsWrite ? segWrite : segRead);

  // Bridge steering of the lower BIOS block
  wire logic lowBiosPositive = lowBiosHit && fromHost && !memSelOn;
  wire logic fwdToHost = memAcc && !fromHost && lowBiosAddr &&
                         !csA_q[A_LOW_BIOS] && decCtrl_q[C_ISA_FWD];

  // ****************************************************************
  // Code selection, fixed priority
  // ****************************************************************
  // IDE control ports win over floppy; floppy over the parallel range it
  // overlaps in the secondary map.
  wire logic groupHit = comAHit || comBHit || lptHit || cfgPageHit || cfgMemHit;
  wire logic [2:0] nextCode =
      (extBiosHit || lowBiosHit) ? CODE_BIOS :
      ideCtlHit ? CODE_IDE1 :
      ideTaskHit ? CODE_IDE0 :
      flopHit ? (dskSync_q ? CODE_FLOPPY : CODE_IDLE) :
      kbdHit ? CODE_KBD :
      rtcHit ? CODE_RTC :
      groupHit ? CODE_GROUP :
      CODE_IDLE;
  wire logic [2:0] nextSub =
      comAHit ? SUB_COMA :
      comBHit ? SUB_COMB :
      lptHit ? SUB_LPT :
      cfgPageHit ? SUB_CPAGE :
      cfgMemHit ? SUB_CFGMEM :
      SUB_NONE;
  wire logic anyCode = (nextCode != CODE_IDLE);
  wire logic flopSel = flopHit && !flopBlocked && !(extBiosHit || lowBiosHit);

  // Outputs registered one cycle after the access is presented
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      encodedSelectCode <= CODE_IDLE;
      groupSubcode <= SUB_NONE;
      xcvrOutputEnableN <= 1'b1;
      floppySelectN <= 1'b1;
      diskCtrlSelect1N <= 1'b1;
      clockChipLatchN <= 1'b1;
      clockChipSelectN <= 1'b1;
      configPageSelectN <= 1'b1;
      configMemSelectN <= 1'b1;
      mainMemSelectN <= 1'b1;
      port92Allow <= 1'b0;
      isaPositiveDecode <= 1'b0;
      hostBusForward <= 1'b0;
    end else begin
      encodedSelectCode <= nextCode;
      groupSubcode <= (nextCode == CODE_GROUP) ? nextSub : SUB_NONE;
      xcvrOutputEnableN <= !anyCode;
      floppySelectN <= !(flopSel && (nextCode == CODE_FLOPPY));
      diskCtrlSelect1N <= !(nextCode == CODE_IDE1);
      clockChipLatchN <= !((nextCode == CODE_RTC) && accIsWrite && !io[0]);
      clockChipSelectN <= !((nextCode == CODE_RTC) && !(accIsWrite && !io[0]));
      configPageSelectN <= !((nextCode == CODE_GROUP) && (nextSub == SUB_CPAGE));
      configMemSelectN <= !((nextCode == CODE_GROUP) && (nextSub == SUB_CFGMEM));
      mainMemSelectN <= !mainMemHit;
      port92Allow <= p92Hit;
      isaPositiveDecode <= lowBiosPositive || extBiosHit;
      hostBusForward <= fwdToHost;
    end
  end

  // ****************************************************************
  // Read data, captured in the setup cycle
  // ****************************************************************
  wire logic [7:0] statusWord = {2'b00, dskSync_q, !mainMemSelectN, !xcvrOutputEnableN,
                                 encodedSelectCode};
  wire logic [7:0] rdByte = idxCsA ? csA_q :
                            idxCsB ? csB_q :
                            idxAttrC ? attrC_q :
                            idxAttrD ? attrD_q :
                            idxCtrl ? decCtrl_q :
                            idxStat ? statusWord : 8'h00;

  // Unmapped reads return zero; upper bytes always read zero
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (setupPhase) begin
      prdata <= {24'h00_0000, (mapped && !pwrite) ? rdByte : 8'h00};
    end
  end

endmodule // util_bus_decode

// [verif/util_bus_decode_assertions.sv]
// Checker for the utility-bus decoder: port-level timing relations.
// Assumes it is bound to util_bus_decode; decode outputs lag one edge.
`timescale 1ns/10ps
module util_bus_decode_assertions
  import util_decode_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic accValid,
  input wire logic accIsMem,
  input wire logic accIsWrite,
  input wire logic [31:0] accAddr,
  input wire logic [2:0] encodedSelectCode,
  input wire logic [2:0] groupSubcode,
  input wire logic xcvrOutputEnableN,
  input wire logic floppySelectN,
  input wire logic diskCtrlSelect1N,
  input wire logic clockChipLatchN,
  input wire logic mainMemSelectN
);
  // ****************************************
  // Assertions
  // ****************************************
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_idle_no_access: assert property (!accValid |=>
    encodedSelectCode == CODE_IDLE && xcvrOutputEnableN) else $error("busy without access");
  a_xcvr_follows_code: assert property (
    xcvrOutputEnableN == (encodedSelectCode == CODE_IDLE)) else $error("xcvr vs code");
  a_sub_only_group: assert property (encodedSelectCode != CODE_GROUP |->
    groupSubcode == SUB_NONE) else $error("subcode outside group");
  a_floppy_sel_code: assert property (!floppySelectN |->
    encodedSelectCode == CODE_FLOPPY) else $error("floppy select without code");
  a_floppy_sel_addr: assert property (!floppySelectN |-> !$past(accIsMem) &&
    $past(accAddr[15:4]) inside {12'h03f, 12'h037}) else $error("floppy range");
  a_ide_second_code: assert property (!diskCtrlSelect1N |->
    encodedSelectCode == CODE_IDE1) else $error("second select without code");
  a_rtc_latch_write: assert property (!clockChipLatchN |-> encodedSelectCode == CODE_RTC &&
    $past(accIsWrite) && !$past(accAddr[0])) else $error("latch strobe cause");
  a_kbd_ports: assert property (encodedSelectCode == CODE_KBD |-> !$past(accIsMem) &&
    $past(accAddr[15:0]) inside {16'h60, 16'h62, 16'h64, 16'h66}) else $error("kbd port");
  a_mem_segment: assert property (!mainMemSelectN |-> $past(accIsMem) &&
    $past(accAddr[31:17]) == 15'h0006) else $error("memory select outside C/D");

  c_floppy: cover property (!floppySelectN);
  c_mem: cover property (!mainMemSelectN);
  c_group: cover property (encodedSelectCode == CODE_GROUP);
endmodule // util_bus_decode_assertions

bind util_bus_decode util_bus_decode_assertions i_chk (.core_clk(core_clk), .nrst(nrst),
  .accValid(accValid), .accIsMem(accIsMem), .accIsWrite(accIsWrite), .accAddr(accAddr),
  .encodedSelectCode(encodedSelectCode), .groupSubcode(groupSubcode),
  .xcvrOutputEnableN(xcvrOutputEnableN), .floppySelectN(floppySelectN),
  .diskCtrlSelect1N(diskCtrlSelect1N), .clockChipLatchN(clockChipLatchN),
  .mainMemSelectN(mainMemSelectN));

// [verif/floppy_drive_model.sv]
// Floppy drive side of the utility bus: disk-change pin and select count.
// Assumes the bench sets mediaChanged after a clock edge.
`timescale 1ns/10ps
module floppy_drive_model (
  input wire logic core_clk,
  input wire logic mediaChanged,
  input wire logic floppySelectN,
  output logic diskChangeIn,
  output int selCount
);
  // Pin reads low while the medium is swapped, else high
  assign diskChangeIn = !mediaChanged;
  // Count strobes so the bench can see the drive was really selected;
  // one process owns the count, the port only mirrors it
  int strobeCount = 0;
  assign selCount = strobeCount;
  always @(posedge core_clk) begin
    if (!floppySelectN) begin
      strobeCount <= strobeCount + 1;
    end
  end
endmodule // floppy_drive_model

// [verif/util_bus_decode_tb.sv]
// Self-checking bench for the utility-bus decoder.
// Assumes zero-wait APB and decode outputs one edge after the access.
`timescale 1ns/10ps
module util_bus_decode_tb import util_decode_pkg::*;;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, accAddr = 32'h0, rdVal;
  logic pready, pslverr, errVal;
  logic accValid = 1'b0, accIsMem = 1'b0, accIsWrite = 1'b0, mediaChanged = 1'b0;
  logic [1:0] accSource = 2'h0;
  logic diskChangeIn, xcvrOutputEnableN, floppySelectN, diskCtrlSelect1N;
  logic clockChipLatchN, clockChipSelectN, configPageSelectN, configMemSelectN;
  logic mainMemSelectN, port92Allow, isaPositiveDecode, hostBusForward;
  logic [2:0] encodedSelectCode, groupSubcode;
  logic [31:0] lptAddr [3] = '{32'h3bc, 32'h378, 32'h27f};
  int selCount;
  int mismatches = 0;
  int checkCount = 0;

  always #50 core_clk = ~core_clk;

  util_bus_decode i_dut (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .accValid, .accIsMem, .accIsWrite, .accSource, .accAddr,
    .diskChangeIn, .encodedSelectCode, .groupSubcode, .xcvrOutputEnableN, .floppySelectN,
    .diskCtrlSelect1N, .clockChipLatchN, .clockChipSelectN, .configPageSelectN,
    .configMemSelectN, .mainMemSelectN, .port92Allow, .isaPositiveDecode, .hostBusForward);
  floppy_drive_model i_drive (.core_clk, .mediaChanged, .floppySelectN, .diskChangeIn,
    .selCount);

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Setup then access; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    for (int i = 0; i <= 16; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
      if (i == 16) begin
        mismatches++;
        final_report();
      end
    end
    rdVal = prdata;
    errVal = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input logic e);
    apb(1'b0, idx, 8'h00);
    chk(rdVal, {24'h0, exp});
    chk(errVal, e);
  endtask

  // One decoded access; outputs stand for the cycle after the sampling edge
  task automatic acc(input logic m, input logic w, input logic [1:0] s, input logic [31:0] a,
                     input logic [2:0] ec, input logic [2:0] sc = SUB_NONE);
    @(posedge core_clk);
    accValid <= 1'b1;
    accIsMem <= m;
    accIsWrite <= w;
    accSource <= s;
    accAddr <= a;
    @(posedge core_clk);
    accValid <= 1'b0;
    #1;
    chk(encodedSelectCode, ec);
    chk(groupSubcode, sc);
    chk(xcvrOutputEnableN, ec == CODE_IDLE);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    rdchk(IDX_CS_A, 8'h07, 1'b0);
    rdchk(IDX_CS_B, 8'h4f, 1'b0);
    rdchk(IDX_ATTR_C, 8'h00, 1'b0);
    rdchk(IDX_ATTR_D, 8'h00, 1'b0);
    rdchk(8'h50, 8'h00, 1'b1);
  endtask

  task automatic t_rtc_kbd();
    acc(0, 1, SRC_HOST, 32'h70, CODE_RTC);
    chk(clockChipLatchN, 1'b0);
    acc(0, 0, SRC_HOST, 32'h77, CODE_RTC);
    chk(clockChipSelectN, 1'b0);
    acc(0, 0, SRC_HOST, 32'h66, CODE_KBD);
    acc(0, 0, SRC_HOST, 32'h61, CODE_IDLE);
    apb(1'b1, IDX_CS_A, 8'h04);
    acc(0, 1, SRC_HOST, 32'h70, CODE_IDLE);
    chk(clockChipLatchN, 1'b1);
    acc(0, 0, SRC_HOST, 32'h60, CODE_IDLE);
  endtask

  task automatic t_disk();
    acc(0, 0, SRC_HOST, 32'h3f0, CODE_IDLE);
    acc(0, 0, SRC_HOST, 32'h3f6, CODE_FLOPPY);
    chk(floppySelectN, 1'b0);
    @(posedge core_clk);
    mediaChanged <= 1'b1;
    repeat (3) @(posedge core_clk);
    acc(0, 0, SRC_HOST, 32'h3f2, CODE_IDLE);
    chk(floppySelectN, 1'b1);
    @(posedge core_clk);
    mediaChanged <= 1'b0;
    apb(1'b1, IDX_CS_A, 8'h1c);
    acc(0, 0, SRC_HOST, 32'h3f7, CODE_IDE1);
    chk(diskCtrlSelect1N, 1'b0);
    acc(0, 0, SRC_HOST, 32'h1f0, CODE_IDE0);
    acc(0, 0, SRC_HOST, 32'h3f1, CODE_FLOPPY);
    apb(1'b1, IDX_CS_A, 8'h3c);
    acc(0, 0, SRC_HOST, 32'h177, CODE_IDE0);
    acc(0, 0, SRC_HOST, 32'h1f0, CODE_IDLE);
    acc(0, 0, SRC_HOST, 32'h376, CODE_IDE1);
    acc(0, 0, SRC_HOST, 32'h3f2, CODE_IDLE);
    acc(0, 0, SRC_HOST, 32'h370, CODE_FLOPPY);
    apb(1'b1, IDX_CS_A, 8'h2c);
    acc(0, 0, SRC_HOST, 32'h170, CODE_IDLE);
    acc(0, 0, SRC_HOST, 32'h376, CODE_FLOPPY);
    chk(floppySelectN, 1'b0);
    chk(selCount > 0, 1'b1);
  endtask

  task automatic t_group();
    apb(1'b1, IDX_CS_A, 8'h00);
    apb(1'b1, IDX_CS_B, 8'h04);
    acc(0, 0, SRC_HOST, 32'h3f8, CODE_GROUP, SUB_COMA);
    acc(0, 0, SRC_HOST, 32'h2ff, CODE_GROUP, SUB_COMB);
    acc(0, 1, SRC_HOST, 32'h92, CODE_IDLE);
    chk(port92Allow, 1'b0);
    apb(1'b1, IDX_CS_B, 8'h40);
    acc(0, 0, SRC_HOST, 32'h3ff, CODE_GROUP, SUB_COMA);
    acc(0, 0, SRC_HOST, 32'h2f8, CODE_IDLE);
    acc(0, 0, SRC_HOST, 32'h92, CODE_IDLE);
    chk(port92Allow, 1'b1);
    apb(1'b1, IDX_CS_B, 8'h0a);
    acc(0, 0, SRC_HOST, 32'h3f8, CODE_IDLE);
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, IDX_CS_B, 8'h0f | 8'(f << 4));
      for (int j = 0; j < 3; j++) begin
        acc(0, 0, SRC_HOST, lptAddr[j], (f == j) ? CODE_GROUP : CODE_IDLE,
            (f == j) ? SUB_LPT : SUB_NONE);
      end
    end
    apb(1'b1, IDX_CS_B, 8'h8f);
    acc(0, 1, SRC_HOST, 32'hc00, CODE_GROUP, SUB_CPAGE);
    chk(configPageSelectN, 1'b0);
    acc(0, 0, SRC_HOST, 32'h8ff, CODE_GROUP, SUB_CFGMEM);
    chk(configMemSelectN, 1'b0);
    acc(0, 0, SRC_HOST, 32'hc00, CODE_IDLE);
    apb(1'b1, IDX_CS_B, 8'h0f);
    acc(0, 1, SRC_HOST, 32'h800, CODE_IDLE);
  endtask

  task automatic t_bios();
    apb(1'b1, IDX_CS_A, 8'h80);
    acc(1, 0, SRC_HOST, 32'hfff80000, CODE_BIOS);
    chk(isaPositiveDecode, 1'b1);
    acc(1, 1, SRC_HOST, 32'hfffdffff, CODE_BIOS);
    acc(1, 0, SRC_HOST, 32'he0000, CODE_IDLE);
    apb(1'b1, IDX_CS_A, 8'h40);
    acc(1, 0, SRC_HOST, 32'hfff80000, CODE_IDLE);
    acc(1, 0, SRC_HOST, 32'hefffc, CODE_BIOS);
    chk(isaPositiveDecode, 1'b1);
    acc(1, 0, 2'h1, 32'hffee1234, CODE_BIOS);
    chk(hostBusForward, 1'b0);
    apb(1'b1, IDX_DEC_CTRL, 8'h08);
    acc(1, 1, 2'h2, 32'hfffe0000, CODE_BIOS);
    chk(hostBusForward, 1'b0);
    apb(1'b1, IDX_CS_A, 8'h00);
    acc(1, 1, 2'h2, 32'he0000, CODE_IDLE);
    chk(hostBusForward, 1'b1);
    apb(1'b1, IDX_DEC_CTRL, 8'h18);
    apb(1'b1, IDX_CS_A, 8'h40);
    acc(1, 0, SRC_HOST, 32'he0000, CODE_BIOS);
    chk(isaPositiveDecode, 1'b0);
  endtask

  task automatic t_mem();
    apb(1'b1, IDX_ATTR_C, 8'h02);
    acc(1, 1, SRC_HOST, 32'hc0000, CODE_IDLE);
    chk(mainMemSelectN, 1'b0);
    acc(1, 0, 2'h1, 32'hc3fff, CODE_IDLE);
    chk(mainMemSelectN, 1'b1);
    apb(1'b1, IDX_ATTR_D, 8'h40);
    acc(1, 0, 2'h2, 32'hdc000, CODE_IDLE);
    chk(mainMemSelectN, 1'b0);
    acc(1, 0, 2'h2, 32'hd8000, CODE_IDLE);
    chk(mainMemSelectN, 1'b1);
    apb(1'b1, IDX_DEC_CTRL, 8'h08);
    acc(1, 0, SRC_HOST, 32'hdc000, CODE_IDLE);
    chk(mainMemSelectN, 1'b1);
    rdchk(IDX_ATTR_D, 8'h40, 1'b0);
    rdchk(IDX_DEC_CTRL, 8'h08, 1'b0);
    rdchk(IDX_STATUS, {2'b00, 1'b1, 2'b00, CODE_IDLE}, 1'b0);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  // Reset held 20 cycles; every scenario judges its own outputs
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    t_regs();
    t_rtc_kbd();
    t_disk();
    t_group();
    t_bios();
    t_mem();
    final_report();
  end
endmodule // util_bus_decode_tb
